//--- hdl/fpc_ctrl.sv
// flash program/erase controller with an AHB-Lite register slave
// assumes the array pulses arr_done once per arr_go when its operation ends
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps

// Function
// - setting start bit 15 launches the operation; hardware clears it when done
// - processor stall output held high for the whole operation
// - page erase of the last page turns on protection
// - gate bit 14 must be one for any program or erase to run
// - bit 13 set by hardware on an improper start sequence
// - bit 6 picks erase or program for the next start
// - code 0011 programs a word, 0001 a row, only with erase bit clear
// - code 0010 erases one eight-row page, only with erase bit set
// - code 1111 with erase bit erases all, only in serial programming mode
// - control bits 12..7 and 5..4 read as zero
// - key writes 55h then AAh must directly precede the start write
// - page erase covers 512 words, row program streams 64 words
// - key register is write-only and reads as zero
// - table writes stay in holding latches until a program commits them
module fpc_ctrl
   import fpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic serial_prog_mode,
   input wire logic arr_done,
   output logic cpu_stall,
   output logic arr_go,
   output fpc_pkg::fpc_cmd_t arr_cmd,
   output logic [23:0] arr_addr,
   output logic arr_wstrobe,
   output logic [23:0] arr_wdata,
   output logic code_protect,
   output logic irq
);
   typedef enum logic [1:0] {FS_IDLE, FS_STREAM, FS_RUN} fpc_state_t;

   // bus pipeline
   logic ap_valid_reg, ap_valid_next;
   logic ap_write_reg, ap_write_next;
   logic [7:0] ap_addr_reg, ap_addr_next;
   logic rd_pend_reg, rd_pend_next;
   logic hreadyout_reg, hreadyout_next;
   logic [31:0] hrdata_reg, hrdata_next;
   // registers and sequencer
   logic [15:0] ctl_reg, ctl_next;
   logic [7:0] page_reg, page_next;
   logic [15:0] tofs_reg, tofs_next;
   logic [ST_W-1:0] stat_reg, stat_next;
   logic [ST_W-1:0] mask_reg, mask_next;
   fpc_state_t st_reg, st_next;
   fpc_cmd_t cmd_reg, cmd_next;
   logic [IDX_W-1:0] idx_reg, idx_next;
   logic stall_reg, stall_next;
   logic go_reg, go_next;
   logic [23:0] addr_reg, addr_next;
   logic wstb_reg, wstb_next;
   logic [23:0] wdat_reg, wdat_next;
   logic prot_reg, prot_next;
   logic irq_reg, irq_next;
   // decoded strobes
   logic wr_now;
   logic key_wr, other_wr, armed;
   logic [23:0] lat_rdata;
   logic [IDX_W-1:0] lat_ridx;
   fpc_cmd_t start_cmd;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // operation select with erase bit to array command
   function automatic fpc_cmd_t op_decode(input logic erase, input logic [3:0] op,
                                          input logic serial);
      fpc_cmd_t c;
      c = CMD_NONE;
      unique case ({erase, op})
         {1'b0, OP_WORD}: c = CMD_WORD;
         {1'b0, OP_ROW}: c = CMD_ROW;
         {1'b1, OP_PAGE}: c = CMD_PAGE;
         {1'b1, OP_BULK}: c = serial ? CMD_BULK : CMD_NONE;
         default: c = CMD_NONE;
      endcase
      return c;
   endfunction

   // readable view of the control register
   function automatic logic [15:0] ctl_view(input logic [15:0] c);
      logic [15:0] v;
      v = 16'h0000;
      v[CTL_START] = c[CTL_START];
      v[CTL_GATE] = c[CTL_GATE];
      v[CTL_ERR] = c[CTL_ERR];
      v[CTL_ERASE] = c[CTL_ERASE];
      v[3:0] = c[3:0];
      return v;
   endfunction

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   assign wr_now = ap_valid_reg && ap_write_reg;
   assign key_wr = wr_now && ap_addr_reg == OFS_KEY;
   assign other_wr = wr_now && ap_addr_reg != OFS_KEY;
   assign lat_ridx = (st_reg == FS_STREAM && cmd_reg == CMD_ROW) ? idx_reg : tofs_reg[6:1];
   assign start_cmd = op_decode(hwdata[CTL_ERASE], hwdata[3:0], serial_prog_mode);

   fpc_unlock u_unlock (
      .hclk(hclk),
      .hresetn(hresetn),
      .key_wr(key_wr),
      .key_data(hwdata[7:0]),
      .other_wr(other_wr),
      .armed(armed)
   );

   fpc_hold_latch u_latch (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_idx(tofs_reg[6:1]),
      .wr_lo(wr_now && ap_addr_reg == OFS_LAT_LO),
      .wr_hi(wr_now && ap_addr_reg == OFS_LAT_HI),
      .wr_data(hwdata[15:0]),
      .rd_idx(lat_ridx),
      .rd_data(lat_rdata)
   );

   // ----------------------------------------
   // AHB-Lite slave pipeline
   // ----------------------------------------
   // writes take no wait state, reads one
   always_comb
   begin
      ap_valid_next = 1'b0;
      ap_write_next = ap_write_reg;
      ap_addr_next = ap_addr_reg;
      rd_pend_next = 1'b0;
      hreadyout_next = 1'b1;
      hrdata_next = hrdata_reg;
      if (hsel && hready && htrans[1])
      begin
         ap_valid_next = 1'b1;
         ap_write_next = hwrite;
         ap_addr_next = {haddr[7:2], 2'b00};
         if (!hwrite)
         begin
            rd_pend_next = 1'b1;
            hreadyout_next = 1'b0;
         end
      end
      if (rd_pend_reg)
      begin
         unique case (ap_addr_reg)
            OFS_CTRL: hrdata_next = {16'h0000, ctl_view(ctl_reg)};
            OFS_PAGE: hrdata_next = {24'h000000, page_reg};
            OFS_TOFS: hrdata_next = {16'h0000, tofs_reg};
            OFS_STAT: hrdata_next = {30'h00000000, stat_reg};
            OFS_MASK: hrdata_next = {30'h00000000, mask_reg};
            default: hrdata_next = 32'h00000000;
         endcase
      end
   end

   // bus registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_valid_reg <= 1'b0;
         ap_write_reg <= 1'b0;
         ap_addr_reg <= 8'h00;
         rd_pend_reg <= 1'b0;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= 32'h00000000;
      end
      else
      begin
         ap_valid_reg <= ap_valid_next;
         ap_write_reg <= ap_write_next;
         ap_addr_reg <= ap_addr_next;
         rd_pend_reg <= rd_pend_next;
         hreadyout_reg <= hreadyout_next;
         hrdata_reg <= hrdata_next;
      end
   end

   // ----------------------------------------
   // registers and operation sequencer
   // ----------------------------------------
   always_comb
   begin
      ctl_next = ctl_reg;
      page_next = page_reg;
      tofs_next = tofs_reg;
      stat_next = stat_reg;
      mask_next = mask_reg;
      st_next = st_reg;
      cmd_next = cmd_reg;
      idx_next = idx_reg;
      stall_next = stall_reg;
      go_next = 1'b0;
      addr_next = addr_reg;
      wstb_next = 1'b0;
      wdat_next = wdat_reg;
      prot_next = prot_reg;
      // software writes; status clear first so a new event wins
      if (wr_now)
      begin
         unique case (ap_addr_reg)
            OFS_PAGE: page_next = hwdata[7:0];
            OFS_TOFS: tofs_next = hwdata[15:0];
            OFS_MASK: mask_next = hwdata[ST_W-1:0];
            OFS_STAT: stat_next = stat_reg & ~hwdata[ST_W-1:0];
            default: ;
         endcase
      end
      if (wr_now && ap_addr_reg == OFS_CTRL && st_reg == FS_IDLE)
      begin
         ctl_next[CTL_GATE] = hwdata[CTL_GATE];
         ctl_next[CTL_ERR] = hwdata[CTL_ERR];
         ctl_next[CTL_ERASE] = hwdata[CTL_ERASE];
         ctl_next[3:0] = hwdata[3:0];
         if (hwdata[CTL_START])
         begin
            if (!armed || !hwdata[CTL_GATE])
            begin
               ctl_next[CTL_ERR] = 1'b1;
               stat_next[ST_ERR] = 1'b1;
            end
            else if (start_cmd != CMD_NONE)
            begin
               ctl_next[CTL_START] = 1'b1;
               ctl_next[CTL_ERR] = 1'b0;
               stall_next = 1'b1;
               cmd_next = start_cmd;
               idx_next = {IDX_W{1'b0}};
               addr_next = {page_reg, tofs_reg};
               if (start_cmd == CMD_ROW)
               begin
                  addr_next = {page_reg, tofs_reg[15:7], 7'h00};
                  st_next = FS_STREAM;
               end
               else if (start_cmd == CMD_WORD)
                  st_next = FS_STREAM;
               else
               begin
                  addr_next = {page_reg, tofs_reg[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
                  go_next = 1'b1;
                  st_next = FS_RUN;
               end
            end
         end
      end
      unique case (st_reg)
         FS_IDLE: ;
         // commit latches to the array one word per cycle
         FS_STREAM:
         begin
            wstb_next = 1'b1;
            wdat_next = lat_rdata;
            if (cmd_reg == CMD_ROW)
               addr_next = {addr_reg[23:7], idx_reg, 1'b0};
            if (cmd_reg == CMD_WORD || idx_reg == IDX_LAST)
            begin
               go_next = 1'b1;
               st_next = FS_RUN;
            end
            idx_next = idx_reg + 1'b1;
         end
         // self-timed array operation
         FS_RUN:
         begin
            if (arr_done)
            begin
               ctl_next[CTL_START] = 1'b0;
               stall_next = 1'b0;
               stat_next[ST_DONE] = 1'b1;
               st_next = FS_IDLE;
               if (cmd_reg == CMD_PAGE &&
                   addr_reg[23:PAGE_LSB] == LAST_PAGE_BASE[23:PAGE_LSB])
                  prot_next = 1'b1;
            end
         end
      endcase
      irq_next = |(stat_next & mask_next);
   end

   // sequencer registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctl_reg <= CTL_RESET;
         page_reg <= 8'h00;
         tofs_reg <= 16'h0000;
         stat_reg <= '0;
         mask_reg <= '0;
         st_reg <= FS_IDLE;
         cmd_reg <= CMD_NONE;
         idx_reg <= '0;
         stall_reg <= 1'b0;
         go_reg <= 1'b0;
         addr_reg <= 24'h000000;
         wstb_reg <= 1'b0;
         wdat_reg <= 24'h000000;
         prot_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         ctl_reg <= ctl_next;
         page_reg <= page_next;
         tofs_reg <= tofs_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         idx_reg <= idx_next;
         stall_reg <= stall_next;
         go_reg <= go_next;
         addr_reg <= addr_next;
         wstb_reg <= wstb_next;
         wdat_reg <= wdat_next;
         prot_reg <= prot_next;
         irq_reg <= irq_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = 1'b0;
   assign cpu_stall = stall_reg;
   assign arr_go = go_reg;
   assign arr_cmd = cmd_reg;
   assign arr_addr = addr_reg;
   assign arr_wstrobe = wstb_reg;
   assign arr_wdata = wdat_reg;
   assign code_protect = prot_reg;
   assign irq = irq_reg;
endmodule

//--- pkg/fpc_pkg.sv
// package for the flash program/erase controller
// assumes one 250 MHz clock and an AHB-Lite master with single word transfers
package fpc_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_KEY = 8'h04;
   localparam logic [7:0] OFS_PAGE = 8'h08;
   localparam logic [7:0] OFS_TOFS = 8'h0c;
   localparam logic [7:0] OFS_LAT_LO = 8'h10;
   localparam logic [7:0] OFS_LAT_HI = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1c;
   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTL_START = 15;
   localparam int CTL_GATE = 14;
   localparam int CTL_ERR = 13;
   localparam int CTL_ERASE = 6;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [3:0] OP_WORD = 4'h3;
   localparam logic [3:0] OP_ROW = 4'h1;
   localparam logic [3:0] OP_PAGE = 4'h2;
   localparam logic [3:0] OP_BULK = 4'hf;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // ----------------------------------------
   // status / mask bits
   // ----------------------------------------
   localparam int ST_DONE = 0;
   localparam int ST_ERR = 1;
   localparam int ST_W = 2;
   // ----------------------------------------
   // array geometry
   // ----------------------------------------
   localparam int ROW_WORDS = 64;
   localparam int IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
   localparam int PAGE_LSB = 10;
   localparam logic [23:0] LAST_PAGE_BASE = 24'h00a800;
   // ----------------------------------------
   // commands to the array
   // ----------------------------------------
   typedef enum logic [2:0] {CMD_NONE, CMD_WORD, CMD_ROW, CMD_PAGE, CMD_BULK} fpc_cmd_t;
endpackage

//--- hdl/fpc_unlock.sv
// unlock key tracker for the flash controller
// assumes key and other register writes arrive as one-cycle strobes
`timescale 1ns/10ps
module fpc_unlock
   import fpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic other_wr,
   output logic armed
);
   typedef enum logic [1:0] {UK_NONE, UK_FIRST, UK_ARMED} fpc_uk_t;
   fpc_uk_t uk_reg, uk_next;

   // ----------------------------------------
   // key sequence
   // ----------------------------------------
   // any write in between drops the sequence
   always_comb
   begin
      uk_next = uk_reg;
      if (other_wr)
         uk_next = UK_NONE;
      else if (key_wr)
      begin
         if (key_data == KEY_FIRST)
            uk_next = UK_FIRST;
         else if (key_data == KEY_SECOND && uk_reg == UK_FIRST)
            uk_next = UK_ARMED;
         else
            uk_next = UK_NONE;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         uk_reg <= UK_NONE;
      else
         uk_reg <= uk_next;
   end

   assign armed = (uk_reg == UK_ARMED);
endmodule

//--- hdl/fpc_hold_latch.sv
// row of holding latches filled by table writes
// assumes writes and reads are indexed by the word within the row
`timescale 1ns/10ps
module fpc_hold_latch
   import fpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [15:0] wr_data,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [23:0] rd_data
);
   logic [23:0] lat_reg [ROW_WORDS];
   logic [23:0] lat_next [ROW_WORDS];

   // ----------------------------------------
   // latch entries
   // ----------------------------------------
   // writes only land here, never in the array
   for (genvar i = 0; i < ROW_WORDS; i++)
   begin : g_lat
      always_comb
      begin
         lat_next[i] = lat_reg[i];
         if (wr_lo && wr_idx == IDX_W'(i))
            lat_next[i][15:0] = wr_data;
         if (wr_hi && wr_idx == IDX_W'(i))
            lat_next[i][23:16] = wr_data[7:0];
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            lat_reg[i] <= 24'hffffff;
         else
            lat_reg[i] <= lat_next[i];
      end
   end

   assign rd_data = lat_reg[rd_idx];
endmodule

//--- tb/fpc_array_model.sv
// behavioural flash array for the controller bench
// assumes one launch at a time; answers with one done pulse
`timescale 1ns/10ps
module fpc_array_model
   import fpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire logic arr_go,
   input wire fpc_pkg::fpc_cmd_t arr_cmd,
   input wire logic [23:0] arr_addr,
   input wire logic arr_wstrobe,
   input wire logic [23:0] arr_wdata,
   output logic arr_done
);
   int go_cnt;
   int wait_cnt;
   fpc_cmd_t last_cmd;
   logic [23:0] last_addr;
   logic [23:0] row_buf [64];
   // record launches and words, answer promptly or slowly
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         arr_done <= 1'b0;
         wait_cnt <= 0;
      end
      else
      begin
         arr_done <= (wait_cnt == 1);
         if (wait_cnt != 0)
            wait_cnt <= wait_cnt - 1;
         if (arr_wstrobe)
            row_buf[arr_addr[6:1]] <= arr_wdata;
         if (arr_go)
         begin
            go_cnt <= go_cnt + 1;
            last_cmd <= arr_cmd;
            last_addr <= arr_addr;
            wait_cnt <= slow ? 40 : 1;
         end
      end
   end
endmodule

//--- tb/fpc_ctrl_monitor.sv
// checker on the array side of the flash controller
// assumes it is bound onto fpc_ctrl, one clock domain
`timescale 1ns/10ps
module fpc_ctrl_monitor
   import fpc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic serial_prog_mode,
   input wire logic arr_done,
   input wire logic cpu_stall,
   input wire logic arr_go,
   input wire fpc_pkg::fpc_cmd_t arr_cmd,
   input wire logic [23:0] arr_addr,
   input wire logic arr_wstrobe,
   input wire logic code_protect
);
   // ----
   // strobes since the last launch
   // ----
   logic [6:0] str_reg;
   logic [6:0] str_next;
   always_comb
   begin
      str_next = arr_go ? 7'h00 : str_reg + {6'h00, arr_wstrobe};
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         str_reg <= 7'h00;
      else
         str_reg <= str_next;
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_launch;
      ##[0:64] arr_go;
   endsequence
   sequence s_release;
      arr_done ##1 !cpu_stall;
   endsequence
   property p_launch;
      $rose(cpu_stall) |-> s_launch;
   endproperty
   property p_release;
      cpu_stall && arr_done |-> s_release;
   endproperty
   property p_go_stall;
      arr_go |-> cpu_stall;
   endproperty
   property p_go_pulse;
      arr_go |=> !arr_go;
   endproperty
   property p_row;
      arr_go && arr_cmd == CMD_ROW |-> str_reg == 7'h3f && arr_wstrobe;
   endproperty
   property p_word;
      arr_go && arr_cmd == CMD_WORD |-> str_reg == 7'h00 && arr_wstrobe;
   endproperty
   property p_erase;
      arr_go && (arr_cmd == CMD_PAGE || arr_cmd == CMD_BULK) |-> str_reg == 7'h00 && !arr_wstrobe;
   endproperty
   property p_bulk;
      arr_go && arr_cmd == CMD_BULK |-> serial_prog_mode;
   endproperty
   property p_latch;
      arr_wstrobe |-> cpu_stall;
   endproperty
   property p_prot_set;
      $rose(code_protect) |-> arr_cmd == CMD_PAGE && arr_addr == LAST_PAGE_BASE;
   endproperty
   property p_prot_hold;
      code_protect |=> code_protect;
   endproperty
   a_launch: assert property (p_launch) else $error("stall without launch");
   a_release: assert property (p_release) else $error("stall kept after done");
   a_go_stall: assert property (p_go_stall) else $error("launch without stall");
   a_go_pulse: assert property (p_go_pulse) else $error("launch pulse too long");
   a_row: assert property (p_row) else $error("row launch not after 64 words");
   a_word: assert property (p_word) else $error("word launch not after 1 word");
   a_erase: assert property (p_erase) else $error("erase launch after words");
   a_bulk: assert property (p_bulk) else $error("bulk erase outside serial mode");
   a_latch: assert property (p_latch) else $error("word strobe while idle");
   a_prot_set: assert property (p_prot_set) else $error("protection set wrongly");
   a_prot_hold: assert property (p_prot_hold) else $error("protection dropped");
endmodule

bind fpc_ctrl fpc_ctrl_monitor u_fpc_ctrl_monitor (
   .hclk(hclk), .hresetn(hresetn), .serial_prog_mode(serial_prog_mode),
   .arr_done(arr_done), .cpu_stall(cpu_stall), .arr_go(arr_go), .arr_cmd(arr_cmd),
   .arr_addr(arr_addr), .arr_wstrobe(arr_wstrobe), .code_protect(code_protect)
);

//--- tb/fpc_ctrl_bench.sv
// self-checking bench for the flash controller
// assumes the array model answers each launch with one done pulse
`timescale 1ns/10ps
module fpc_ctrl_bench;
   import fpc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, serial_prog_mode, slow;
   logic arr_done, cpu_stall, arr_go, arr_wstrobe, code_protect, irq;
   logic [31:0] haddr, hwdata, hrdata, rdat, r;
   logic [31:0] seed = 32'h36fc;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [23:0] arr_addr, arr_wdata;
   logic [23:0] ptr;
   logic [23:0] lat [64];
   logic [15:0] codes [9] = '{16'h4003, 16'h4001, 16'h4042, 16'h404f, 16'h4043,
      16'h4041, 16'h4002, 16'h400f, 16'h404f};
   fpc_cmd_t arr_cmd;
   int error_cnt, cmp_count;
   assign hready = hreadyout;
   fpc_ctrl u_fpc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .arr_done(arr_done),
      .serial_prog_mode(serial_prog_mode), .cpu_stall(cpu_stall), .arr_go(arr_go),
      .arr_cmd(arr_cmd), .arr_addr(arr_addr), .arr_wstrobe(arr_wstrobe),
      .arr_wdata(arr_wdata), .code_protect(code_protect), .irq(irq));
   fpc_array_model u_fpc_array_model (.hclk(hclk), .hresetn(hresetn), .slow(slow),
      .arr_go(arr_go), .arr_cmd(arr_cmd), .arr_addr(arr_addr), .arr_wstrobe(arr_wstrobe),
      .arr_wdata(arr_wdata), .arr_done(arr_done));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // command the array should see for a control value
   function automatic fpc_cmd_t exp_cmd(input logic [15:0] c, input logic spm);
      if (!c[14])
         return CMD_NONE;
      case ({c[6], c[3:0]})
         5'h03: return CMD_WORD;
         5'h01: return CMD_ROW;
         5'h12: return CMD_PAGE;
         5'h1f: return spm ? CMD_BULK : CMD_NONE;
         default: return CMD_NONE;
      endcase
   endfunction
   task automatic wrap_up();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         error_cnt++;
         wrap_up();
      end
   endtask
   // one single-word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rdat = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), rdat, e);
   endtask
   // key mode 0 good, 1 swapped, 2 write between key and start
   task automatic op(input logic [15:0] c, input int km, input logic [31:0] ex);
      int g;
      int n;
      fpc_cmd_t e;
      g = u_fpc_array_model.go_cnt;
      wr(OFS_CTRL, {16'h0, c});
      // mode pin settled by now, so the expectation sees its new level
      e = km == 0 ? exp_cmd(c, serial_prog_mode) : CMD_NONE;
      wr(OFS_KEY, km == 1 ? 32'haa : 32'h55);
      wr(OFS_KEY, km == 1 ? 32'h55 : 32'haa);
      if (km == 2)
         wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, {16'h0, c | 16'h8000});
      @(negedge hclk);
      chk("stall", cpu_stall, e != CMD_NONE);
      n = 0;
      while (cpu_stall !== 1'b0 && n < 300)
      begin
         @(negedge hclk);
         n++;
      end
      chk("stall end", n < 300, 1);
      if (n >= 300)
         wrap_up();
      chk("launches", u_fpc_array_model.go_cnt - g, e != CMD_NONE);
      if (e != CMD_NONE)
         chk("cmd", u_fpc_array_model.last_cmd, e);
      if (e == CMD_WORD)
         chk("word addr", u_fpc_array_model.last_addr, ptr);
      if (e == CMD_PAGE || e == CMD_BULK)
         chk("base", u_fpc_array_model.last_addr, ptr & 24'hfffc00);
      rd(OFS_CTRL, ex);
   endtask
   // ----
   // clock and sequence
   // ----
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      serial_prog_mode = 1'b0;
      slow = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_KEY, 32'h0);
      rd(8'h40, 32'h0);
      wr(OFS_CTRL, 32'hffff);
      rd(OFS_CTRL, 32'h604f);
      op(16'h0003, 0, 32'h2003);
      op(16'h4003, 1, 32'h6003);
      op(16'h4003, 2, 32'h6003);
      wr(OFS_PAGE, 32'h01);
      // reload the whole row of latches before the row program
      for (int i = 0; i < 64; i++)
      begin
         r = rnd();
         lat[i] = r[23:0];
         wr(OFS_TOFS, 32'h0200 + 2 * i);
         wr(OFS_LAT_LO, {16'h0, lat[i][15:0]});
         wr(OFS_LAT_HI, {24'h0, lat[i][23:16]});
      end
      ptr = 24'h01027e; // last table pointer written above
      for (int k = 0; k < 9; k++)
      begin
         r = rnd();
         @(posedge hclk);
         serial_prog_mode <= k == 3 ? 1'b1 : (k == 8 ? 1'b0 : r[0]);
         slow <= r[1];
         op(codes[k], 0, {16'h0, codes[k]});
      end
      for (int i = 0; i < 64; i++)
         chk("row word", u_fpc_array_model.row_buf[i], lat[i]);
      chk("protect", code_protect, 1'b0);
      wr(OFS_PAGE, {24'h0, LAST_PAGE_BASE[23:16]});
      wr(OFS_TOFS, {16'h0, LAST_PAGE_BASE[15:0]});
      ptr = LAST_PAGE_BASE;
      op(16'h4042, 0, 32'h4042);
      chk("protect", code_protect, 1'b1);
      rd(OFS_STAT, 32'h3);
      wr(OFS_MASK, 32'h1);
      repeat (2) @(negedge hclk);
      chk("irq", irq, 1'b1);
      wr(OFS_STAT, 32'h3);
      repeat (2) @(negedge hclk);
      chk("irq", irq, 1'b0);
      op(16'h0003, 0, 32'h2003);
      chk("irq", irq, 1'b0);
      wr(OFS_MASK, 32'h2);
      repeat (2) @(negedge hclk);
      chk("irq", irq, 1'b1);
      chk("resp", hresp, 1'b0);
      wrap_up();
   end
endmodule
